/* File: rtl/bewr_pkg.sv */
// package for the byte-enabled write request block
// assumes one clock domain; all users import bewr_pkg::*
package bewr_pkg;
  localparam int LINE_BYTES = 64;
  localparam int DATA_W = 512;
  // mode bit of the header
  localparam logic WHOLE_LINE_MODE = 1'b0;
  localparam logic PARTIAL_LINE_MODE = 1'b1;
  localparam logic [3:0] WRITE_LINE_INVALIDATE = 4'h0;
  localparam logic [1:0] AUTO_CHANNEL = 2'h0;
  // apb byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_WR_COUNT = 8'h08;
  localparam logic [7:0] OFF_ERR_COUNT = 8'h0C;
  localparam logic [7:0] OFF_PEEK_SEL = 8'h10;
  localparam logic [7:0] OFF_PEEK_DATA = 8'h14;
  // reset values
  localparam logic CTRL_DRAIN_RST = 1'b1;
  localparam logic [7:0] PEEK_SEL_RST = 8'h00;
  // 80-bit write request header, bit 79 first
  typedef struct packed {
    logic [5:0] byte_len;             // 79:74
    logic [1:0] channel_select;       // 73:72
    logic sop;                        // 71
    logic mode;                       // 70
    logic [1:0] line_count_code;      // 69:68
    logic [3:0] req_type;             // 67:64
    logic [5:0] byte_start;           // 63:58
    logic [41:0] addr;                // 57:16
    logic [15:0] mdata;               // 15:0
  } bewr_hdr_t;
  typedef struct packed {
    bewr_hdr_t hdr;
    logic [DATA_W-1:0] data;
  } bewr_req_t;
endpackage

/* File: rtl/bewr_top.sv */
// byte-enabled write request sink: queues write beats, merges them into a line store
// assumes requests come from logic on pclk and software uses apb
//
// How it works
// RQ1 - only selected bytes change, others kept
// RQ2 - little-endian, element keeps contiguous bytes
// RQ3 - data sits at its line offset
// RQ4 - byte 0 is bits 7:0, 63 is 511:504
// RQ5 - byte count grows toward high bytes
// RQ6 - partial writes use line count zero
// RQ7 - byte range must stay within byte 63
// RQ8 - count 79:74, start 63:58, mode bit 70
// RQ9 - one mode throughout a burst
// RQ10 - unaligned buffers: partial ends, whole middle
// RQ11 - line address in address, offset in start
// RQ12 - aligned middle lines as two-beat burst
// RQ13 - burst beats complete before other requests
// RQ14 - bursts start on naturally aligned lines
// RQ15 - partial writes are single-beat invalidating writes
`timescale 1ns/10ps
module bewr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r, rp_r;
  logic [$clog2(DEPTH+1)-1:0] cnt_r, cnt_nxt;
  logic ready_r;
  wire push = ce && in_valid && ready_r;
  wire pop = ce && out_ready && (cnt_r != '0);
  assign cnt_nxt = cnt_r + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
  assign in_ready = ready_r;
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rp_r];
  assign level = cnt_r;
  // storage has no reset; only pointers, count and ready need one
  always_ff @(posedge clk) begin
    if (push) mem[wp_r] <= in_data;
  end
  // ready is registered so a full queue refuses the very next beat
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      ready_r <= 1'b1;
    end else if (ce) begin
      if (push) wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      if (pop) rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      cnt_r <= cnt_nxt;
      ready_r <= (cnt_nxt != ($clog2(DEPTH+1))'(DEPTH));
    end
  end
endmodule // bewr_fifo

module bewr_top import bewr_pkg::*; #(
  parameter int LINES = 16,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_valid,
  input wire bewr_hdr_t tx_hdr,
  input wire logic [DATA_W-1:0] tx_data,
  output logic tx_ready
);
  localparam int LW = $clog2(LINES);

  // byte lanes enabled by a request; whole-line mode enables all
  function automatic logic [LINE_BYTES-1:0] lane_mask(input bewr_hdr_t h);
    logic [6:0] hi;
    hi = 7'(h.byte_start) + 7'(h.byte_len);
    for (int i = 0; i < LINE_BYTES; i++) begin
      lane_mask[i] = (h.mode == WHOLE_LINE_MODE) ||
                     ((7'(i) >= 7'(h.byte_start)) && (7'(i) < hi));
    end
  endfunction

  // byte i covers data bits 8*i+7 : 8*i
  function automatic logic [DATA_W-1:0] bit_mask(input logic [LINE_BYTES-1:0] m);
    for (int i = 0; i < LINE_BYTES; i++) bit_mask[8*i +: 8] = {8{m[i]}};
  endfunction

  logic [DATA_W-1:0] line_mem [LINES];
  bewr_req_t q_out;
  logic q_valid, q_ready, in_ready;
  logic [$clog2(FIFO_DEPTH+1)-1:0] q_level;
  logic drain_r, pready_r, pslverr_r, tx_ready_r;
  logic [31:0] prdata_r, wr_cnt_r, err_cnt_r;
  logic [7:0] peek_sel_r;
  logic [1:0] beats_left_r;
  logic burst_mode_r;

  // requests come from same-clock logic, so no synchroniser
  // only beats offered under the outward ready are queued, so a held beat is never taken twice
  bewr_fifo #(.WIDTH($bits(bewr_req_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .ce(ce),
    .in_valid(tx_valid && tx_ready_r),
    .in_ready(in_ready),
    .in_data({tx_hdr, tx_data}),
    .out_valid(q_valid),
    .out_ready(q_ready),
    .out_data(q_out),
    .level(q_level)
  );

  // drain stalls when software clears the drain bit, so the queue really fills
  assign q_ready = drain_r;
  wire wr_fire = ce && q_valid && drain_r;
  wire [LW-1:0] wr_line = q_out.hdr.addr[LW-1:0];
  wire [LINE_BYTES-1:0] wr_lanes = lane_mask(q_out.hdr); // RQ5 RQ8
  wire [DATA_W-1:0] wr_bits = bit_mask(wr_lanes); // RQ4
  wire [DATA_W-1:0] old_line = line_mem[wr_line];
  wire [DATA_W-1:0] new_line = (old_line & ~wr_bits) | (q_out.data & wr_bits); // RQ1 RQ2
  wire partial = (q_out.hdr.mode == PARTIAL_LINE_MODE);
  wire overrun = partial && ((7'(q_out.hdr.byte_start) + 7'(q_out.hdr.byte_len)) > 7'd64);
  wire cont_beat = !q_out.hdr.sop && (beats_left_r != 2'd0);
  wire bad_beat = (partial && q_out.hdr.line_count_code != 2'd0) || overrun ||
                  (cont_beat && (q_out.hdr.mode != burst_mode_r));

  // merge: lanes outside the selected range keep the stored bytes
  always_ff @(posedge pclk) begin
    if (wr_fire) line_mem[wr_line] <= new_line; // RQ1
  end

  // burst tracking flags a mode change inside a burst as an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      beats_left_r <= 2'd0;
      burst_mode_r <= WHOLE_LINE_MODE;
      wr_cnt_r <= 32'h0000_0000;
      err_cnt_r <= 32'h0000_0000;
    end else if (wr_fire) begin
      if (q_out.hdr.sop) begin
        beats_left_r <= q_out.hdr.line_count_code;
        burst_mode_r <= q_out.hdr.mode;
      end else if (beats_left_r != 2'd0) beats_left_r <= beats_left_r - 2'd1;
      wr_cnt_r <= wr_cnt_r + 32'h0000_0001;
      if (bad_beat) err_cnt_r <= err_cnt_r + 32'h0000_0001;
    end
  end

  // apb decode; unmapped offsets answer with pslverr
  wire acc = psel && penable && !pready_r;
  wire [3:0] pk_word = peek_sel_r[3:0];
  wire [LW-1:0] pk_line = LW'(peek_sel_r[7:4]);
  wire [31:0] peek_word = line_mem[pk_line][32*pk_word +: 32];
  wire hit = (paddr == OFF_CTRL) || (paddr == OFF_STATUS) || (paddr == OFF_WR_COUNT) ||
             (paddr == OFF_ERR_COUNT) || (paddr == OFF_PEEK_SEL) || (paddr == OFF_PEEK_DATA);
  wire [31:0] rd_mux =
    (paddr == OFF_CTRL) ? {31'h0, drain_r} :
    (paddr == OFF_STATUS) ? {24'h0, beats_left_r, burst_mode_r, 1'b0, 4'(q_level)} :
    (paddr == OFF_WR_COUNT) ? wr_cnt_r :
    (paddr == OFF_ERR_COUNT) ? err_cnt_r :
    (paddr == OFF_PEEK_SEL) ? {24'h0, peek_sel_r} :
    (paddr == OFF_PEEK_DATA) ? peek_word : 32'h0000_0000;

  // one wait state: pready rises at the first access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      drain_r <= CTRL_DRAIN_RST;
      peek_sel_r <= PEEK_SEL_RST;
      tx_ready_r <= 1'b0;
    end else if (ce) begin
      pready_r <= acc;
      pslverr_r <= acc && !hit;
      prdata_r <= (acc && !pwrite) ? rd_mux : 32'h0000_0000;
      if (acc && pwrite && paddr == OFF_CTRL) drain_r <= pwdata[0];
      if (acc && pwrite && paddr == OFF_PEEK_SEL) peek_sel_r <= pwdata[7:0];
      tx_ready_r <= in_ready && (q_level < ($clog2(FIFO_DEPTH+1))'(FIFO_DEPTH - 1));
    end
  end

  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign prdata = prdata_r;
  // a flop-driven ready lags a cycle, so it drops one slot early
  assign tx_ready = tx_ready_r;

  // bytes outside the lane mask are unchanged after a write
  property p_keep;
    @(posedge pclk) disable iff (!presetn)
    wr_fire |=> ((line_mem[$past(wr_line)] & ~$past(wr_bits)) ==
                 ($past(old_line) & ~$past(wr_bits)));
  endproperty
  a_keep: assert property (p_keep) else $error("unselected bytes changed"); // RQ1
  // selected bytes take the data at the same offset
  property p_take;
    @(posedge pclk) disable iff (!presetn)
    wr_fire |=> ((line_mem[$past(wr_line)] & $past(wr_bits)) ==
                 ($past(q_out.data) & $past(wr_bits)));
  endproperty
  a_take: assert property (p_take) else $error("selected bytes not written"); // RQ2
  // byte 0 lane drives bits 7:0 and byte 63 bits 511:504
  property p_lane_ends;
    @(posedge pclk) disable iff (!presetn)
    wr_fire |-> (wr_bits[7:0] == {8{wr_lanes[0]}}) &&
                (wr_bits[511:504] == {8{wr_lanes[63]}});
  endproperty
  a_lane_ends: assert property (p_lane_ends) else $error("lane map wrong"); // RQ4
  // a partial write within the line enables exactly byte_len lanes
  property p_count;
    @(posedge pclk) disable iff (!presetn)
    (wr_fire && partial && !overrun) |-> ($countones(wr_lanes) == int'(q_out.hdr.byte_len));
  endproperty
  a_count: assert property (p_count) else $error("lane count differs"); // RQ5
  // mode bit clear selects every lane
  property p_whole;
    @(posedge pclk) disable iff (!presetn)
    (wr_fire && !partial) |-> (wr_lanes == {LINE_BYTES{1'b1}});
  endproperty
  a_whole: assert property (p_whole) else $error("whole line not full"); // RQ8
  // ready falls once all but one entry are used
  property p_backpressure;
    @(posedge pclk) disable iff (!presetn)
    (ce && q_level >= ($clog2(FIFO_DEPTH+1))'(FIFO_DEPTH - 1)) |=> !tx_ready;
  endproperty
  a_backpressure: assert property (p_backpressure) else $error("ready while full");
  // apb answers two edges after the setup edge
  property p_apb;
    @(posedge pclk) disable iff (!presetn)
    (ce && psel && !penable) ##1 (ce && psel && penable) |=> pready;
  endproperty
  a_apb: assert property (p_apb) else $error("apb answer late");
  // a beat offered while ready is high always finds room in the queue
  property p_room;
    @(posedge pclk) disable iff (!presetn)
    (ce && tx_valid && tx_ready) |-> in_ready;
  endproperty
  a_room: assert property (p_room) else $error("beat taken without room");
  // a partial write enables one unbroken run of lanes from the start byte
  property p_span;
    @(posedge pclk) disable iff (!presetn)
    (wr_fire && partial && !overrun) |->
      (wr_lanes == (((64'h1 << q_out.hdr.byte_len) - 64'h1) << q_out.hdr.byte_start));
  endproperty
  a_span: assert property (p_span) else $error("lane run not contiguous"); // RQ2
  // read data is zero outside the answer cycle, so stale words never leak
  property p_rd_idle;
    @(posedge pclk) disable iff (!presetn)
    !pready |-> (prdata == 32'h0000_0000);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer");
  // each transfer gets a single-cycle answer
  property p_pulse;
    @(posedge pclk) disable iff (!presetn)
    (ce && pready) |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("answer stands too long");
  // an error answer never stands without pready
  property p_slverr;
    @(posedge pclk) disable iff (!presetn)
    pslverr |-> pready;
  endproperty
  a_slverr: assert property (p_slverr) else $error("error flag without answer");
  // a low clock enable holds queue, counters and control as they are
  property p_freeze;
    @(posedge pclk) disable iff (!presetn)
    !ce |=> ($stable(q_level) && $stable(wr_cnt_r) && $stable(drain_r) && $stable(tx_ready));
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");
  // every drained beat is counted once
  property p_wr_count;
    @(posedge pclk) disable iff (!presetn)
    wr_fire |=> (wr_cnt_r == $past(wr_cnt_r) + 32'h0000_0001);
  endproperty
  a_wr_count: assert property (p_wr_count) else $error("beat not counted");
  // a flagged beat bumps the error count by one
  property p_err;
    @(posedge pclk) disable iff (!presetn)
    (wr_fire && bad_beat) |=> (err_cnt_r == $past(err_cnt_r) + 32'h0000_0001);
  endproperty
  a_err: assert property (p_err) else $error("bad beat not counted");
  c_partial: cover property (@(posedge pclk) disable iff (!presetn) wr_fire && partial);
  c_burst: cover property (@(posedge pclk) disable iff (!presetn)
    wr_fire && !partial && q_out.hdr.line_count_code == 2'd1);
  c_full: cover property (@(posedge pclk) disable iff (!presetn) !tx_ready && q_valid);
  c_err: cover property (@(posedge pclk) disable iff (!presetn) wr_fire && bad_beat);
  c_freeze: cover property (@(posedge pclk) disable iff (!presetn) !ce && q_valid);
endmodule // bewr_top

/* File: testbench/bewr_requester.sv */
// requester model: issues write beats on the tx stream of the sink
// assumes the sink takes a beat at a rising pclk with tx_valid and tx_ready high
`timescale 1ns/10ps
module bewr_requester import bewr_pkg::*; (
  input wire logic pclk,
  input wire logic tx_ready,
  output logic tx_valid,
  output bewr_hdr_t tx_hdr,
  output logic [DATA_W-1:0] tx_data
);
  initial begin
    tx_valid = 1'b0;
    tx_hdr = '0;
    tx_data = '0;
  end
  // one beat per call, single line; so marks the first beat of a request; held until taken
  // released lines show the inverse so stale values never pass for good ones
  task automatic send(input logic md, input logic [1:0] lc, input logic [5:0] st,
    input logic [5:0] ln, input logic [41:0] a, input logic [DATA_W-1:0] d, input logic so);
    bewr_hdr_t h;
    h = '{byte_len: ln, channel_select: AUTO_CHANNEL, sop: so, mode: md,
      line_count_code: lc, req_type: WRITE_LINE_INVALIDATE, byte_start: st,
      addr: a, mdata: 16'h0000};
    tx_valid <= 1'b1;
    tx_hdr <= h;
    tx_data <= d;
    @(posedge pclk);
    while (tx_ready !== 1'b1) @(posedge pclk);
    tx_valid <= 1'b0;
    tx_hdr <= ~h;
    tx_data <= ~d;
  endtask
endmodule // bewr_requester

/* File: testbench/test_bewr_top.sv */
// self-checking bench for the byte-enabled write sink
// assumes the requester model on the stream and an apb master here
`timescale 1ns/10ps
module test_bewr_top import bewr_pkg::*;;
  logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, tx_valid, tx_ready;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  bewr_hdr_t tx_hdr;
  logic [DATA_W-1:0] tx_data;
  logic [64:0] exp_q[$];
  logic [7:0] mem[16][64];
  int fail_count = 0, checked = 0, cyc = 0, beats = 0;
  logic beat_sop = 1'b1;
  bewr_top #(.LINES(16), .FIFO_DEPTH(8)) i_bewr_top (.pclk(pclk), .presetn(presetn),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_valid(tx_valid), .tx_hdr(tx_hdr), .tx_data(tx_data), .tx_ready(tx_ready));
  bewr_requester i_bewr_requester (.pclk(pclk), .tx_ready(tx_ready),
    .tx_valid(tx_valid), .tx_hdr(tx_hdr), .tx_data(tx_data));
  initial begin
    forever #50 pclk = ~pclk;
  end
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // a hang past the expected run length counts as a mismatch
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  // watcher: each answer is paired with the oldest note {mask, slverr, data}
  always @(posedge pclk) begin
    logic [64:0] n;
    if (pready === 1'b1) begin
      if (exp_q.size() == 0) check(33'h1FFFFFFFF, 33'h0);
      else begin
        n = exp_q.pop_front();
        check({pslverr, prdata & n[64:33]}, {n[32], n[31:0] & n[64:33]});
      end
    end
  end
  // one apb transfer; waits for pready without assuming its latency
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    input logic [64:0] note);
    exp_q.push_back(note);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // bench model of the line store is updated as each beat is issued
  task automatic beat(input logic md, input logic [1:0] lc, input int st, input int ln,
    input int l);
    logic [DATA_W-1:0] d;
    for (int i = 0; i < 64; i++) d[8*i+:8] = 8'($urandom());
    for (int i = 0; i < 64; i++)
      if (md == WHOLE_LINE_MODE || (i >= st && i < st + ln)) mem[l][i] = d[8*i+:8];
    beats++;
    i_bewr_requester.send(md, lc, 6'(st), 6'(ln), {38'h0, 4'(l)}, d, beat_sop);
    repeat ($urandom_range(1, 3)) @(posedge pclk);
  endtask
  task automatic peek_line(input int l);
    for (int w = 0; w < 16; w++) begin
      apb(1'b1, OFF_PEEK_SEL, {24'h0, 4'(l), 4'(w)}, 65'h0);
      apb(1'b0, OFF_PEEK_DATA, 32'h0, {32'hFFFFFFFF, 1'b0, mem[l][4*w+3],
        mem[l][4*w+2], mem[l][4*w+1], mem[l][4*w]});
    end
  endtask
  initial begin
    int st;
    void'($urandom(20));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFF_CTRL, 32'h0, {32'h1, 1'b0, 31'h0, CTRL_DRAIN_RST});
    apb(1'b0, OFF_PEEK_SEL, 32'h0, {32'hFF, 1'b0, 24'h0, PEEK_SEL_RST});
    apb(1'b0, 8'h18, 32'h0, {32'hFFFFFFFF, 1'b1, 32'h0});
    apb(1'b1, 8'h1C, 32'h5A, {32'h0, 1'b1, 32'h0});
    for (int l = 0; l < 4; l++) beat(WHOLE_LINE_MODE, 2'h0, 0, 64, l);
    // unaligned buffer: partial head, two-beat whole middle, partial tail
    beat(PARTIAL_LINE_MODE, 2'h0, 8'h2C, 8'h14, 1);
    beat(WHOLE_LINE_MODE, 2'h1, 0, 64, 2);
    beat_sop = 1'b0;
    beat(WHOLE_LINE_MODE, 2'h1, 0, 64, 3);
    beat_sop = 1'b1;
    beat(PARTIAL_LINE_MODE, 2'h0, 0, 4, 3);
    beat(PARTIAL_LINE_MODE, 2'h0, 8'h04, 8'h11, 2);
    for (int k = 0; k < 6; k++) begin
      st = $urandom_range(0, 63);
      beat(PARTIAL_LINE_MODE, 2'h0, st, $urandom_range(1, st == 0 ? 63 : 64 - st),
        $urandom_range(0, 3));
    end
    // a partial beat inside a whole-line burst is flagged but still merged
    beat(WHOLE_LINE_MODE, 2'h1, 0, 64, 0);
    beat_sop = 1'b0;
    beat(PARTIAL_LINE_MODE, 2'h0, 16, 8, 1);
    beat_sop = 1'b1;
    beat(PARTIAL_LINE_MODE, 2'h1, 8, 4, 0);
    beat(PARTIAL_LINE_MODE, 2'h0, 8'h3C, 8, 1);
    repeat (4) @(posedge pclk);
    for (int l = 0; l < 4; l++) peek_line(l);
    apb(1'b0, OFF_WR_COUNT, 32'h0, {32'hFFFFFFFF, 1'b0, 32'(beats)});
    apb(1'b0, OFF_ERR_COUNT, 32'h0, {32'hFFFFFFFF, 1'b0, 32'h3});
    // stall draining so the queue fills until the stream refuses
    apb(1'b1, OFF_CTRL, 32'h0, 65'h0);
    for (int l = 4; l < 11; l++) beat(WHOLE_LINE_MODE, 2'h0, 0, 64, l);
    // ready lags the level by one edge, so let it settle first
    @(posedge pclk);
    check({32'h0, tx_ready}, 33'h0);
    apb(1'b0, OFF_STATUS, 32'h0, {32'hF, 1'b0, 32'h7});
    apb(1'b1, OFF_CTRL, 32'h1, 65'h0);
    // two beats drained by now; freezing must hold the level at five
    ce <= 1'b0;
    repeat (6) @(posedge pclk);
    ce <= 1'b1;
    // the setup edge drains one more before the access edge reads the level
    apb(1'b0, OFF_STATUS, 32'h0, {32'hF, 1'b0, 32'h4});
    repeat (12) @(posedge pclk);
    check({32'h0, tx_ready}, 33'h1);
    apb(1'b0, OFF_STATUS, 32'h0, {32'hF, 1'b0, 32'h0});
    apb(1'b0, OFF_WR_COUNT, 32'h0, {32'hFFFFFFFF, 1'b0, 32'(beats)});
    peek_line(10);
    tally_and_finish();
  end
endmodule // test_bewr_top
